// ### core/bridge_regs_defs.svh
// offsets, field positions, reset values and timing values in ns of the bridge registers
`ifndef BRIDGE_REGS_DEFS_SVH
`define BRIDGE_REGS_DEFS_SVH
`define OFS_BRIDGE_FLAGS 8'h50
`define OFS_BRIDGE_CTRL 8'h54
`define OFS_AUDIO_PATH 8'h55
`define OFS_LINK_STATUS 8'h5a
`define OFS_FREQ_WINDOW 8'h5c
`define OFS_FREQ_LOW 8'h5d
`define BC_EXT_CTRL 7
`define BC_RX_INT_EN 6
`define BC_REM_ID_DIS 5
`define BC_AUTO_RECEIVER_INIT_DISABLE 4
`define BC_TDM_AUDIO 2
`define BC_AUDIO_LOCAL 1
`define BC_AUX_AUDIO 0
`define AP_TDM_PARALLEL 7
`define AP_I2S_OUT 6
`define AP_FLUSH_TYPE 3
`define AP_FLUSH_AIF 2
`define AP_FLUSH_AVI 1
`define AP_FLUSH_ACR 0
`define BF_RX_INT 6
`define FW_SEL_LSB 3
`define MASK_BRIDGE_CTRL 8'hf7
`define MASK_AUDIO_PATH 8'hcf
`define RST_BRIDGE_CTRL 8'h00
`define RST_AUDIO_PATH 8'h0c
`define RST_WINDOW_SEL 2'h0
`define RST_MIN_FREQ 6'h06
`define HYST_MHZ 8'h02
`define PORT_MODE_SINGLE0 2'h1
`define CLK_PERIOD_NS 25
`define STBL_T0_NS 40000
`define STBL_T1_NS 80000
`define STBL_T2_NS 320000
`define STBL_T3_NS 1280000
`endif

// ### core/bridge_regs_pkg.sv
// types shared by the bridge register bank
package bridge_regs_pkg;
  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_RUN = 2'b10
  } cfg_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// ### core/freq_watch_if.sv
// signals between the register bank and the frequency watcher
`timescale 1ns/1ps
interface freq_watch_if;
  logic [7:0] meas_mhz;
  logic [5:0] min_mhz;
  logic [1:0] window_sel;
  logic no_clock;
  logic settled;
  modport ctrl (output meas_mhz, output min_mhz, output window_sel,
    input no_clock, input settled);
  modport watch (input meas_mhz, input min_mhz, input window_sel,
    output no_clock, output settled);
endinterface

// ### core/freq_watch.sv
// input clock frequency watcher: low-frequency and stability flags
`timescale 1ns/1ps
`include "bridge_regs_defs.svh"
module freq_watch #(
  parameter int CYC_W0 = 1600,
  parameter int CYC_W1 = 3200,
  parameter int CYC_W2 = 12800,
  parameter int CYC_W3 = 51200
) (
  input wire logic clk,
  input wire logic rst,
  freq_watch_if.watch fw
);
  logic [7:0] ref_reg;
  logic [15:0] cnt_reg;
  logic no_clock_reg;
  logic settled_reg;
  logic moved;
  logic [15:0] limit;

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  assign moved = abs_diff(fw.meas_mhz, ref_reg) > `HYST_MHZ;
  assign limit = (fw.window_sel == 2'h0) ? 16'(CYC_W0) :
                 (fw.window_sel == 2'h1) ? 16'(CYC_W1) :
                 (fw.window_sel == 2'h2) ? 16'(CYC_W2) : 16'(CYC_W3);

  // ************************************
  // measurement tracking
  // ************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_reg <= 8'h00;
      cnt_reg <= 16'h0000;
      settled_reg <= 1'b0;
      no_clock_reg <= 1'b1;
    end else begin
      no_clock_reg <= fw.meas_mhz <= {2'h0, fw.min_mhz};
      if (moved) begin
        ref_reg <= fw.meas_mhz;
        cnt_reg <= 16'h0000;
        settled_reg <= 1'b0;
      end else if (cnt_reg >= limit) begin
        settled_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  assign fw.no_clock = no_clock_reg;
  assign fw.settled = settled_reg;
endmodule // freq_watch

// ### core/bridge_audio_link_status_regs.sv
// bridge control, audio path and serial link status register bank
// Overview of operation
// - external control disables internal bridge controller and receiver auto-init
// - receiver interrupt drives active-low interrupt pin when enabled
// - remote display-ID load runs unless its disable bit is set
// - receiver auto-init runs unless its disable bit is written 1
// - bit 2 enables time-division multiplexed audio handling
// - bit 1 picks extracted audio (0) or local I2S audio (1)
// - bit 0, strapped from pin A, enables auxiliary audio channel
// - audio bit 7 enables multi-slot to parallel converter
// - extracted audio drives I2S pins only when source is extracted
// - flush audio FIFO on audio type change when enabled
// - flush audio FIFO on audio infoframe checksum change when enabled
// - flush audio FIFO on video infoframe checksum change when enabled
// - flush audio FIFO on clock-regeneration N or CTS change when enabled
// - status bit 7 shows downstream link detected and ready
// - status bit 6 needs active transmitter, far lock, valid input, right mode
// - port mode field reports transmit mode while bit 6 is set
// - status bits 3 and 2 show good decode and input PLL lock
// - status bit 1 shows no clock above low-frequency threshold
// - status bit 0 shows input clock frequency judged stable
// - low-frequency threshold is six bits in MHz, default 6
// - stable after staying in window 40us, 80us, 320us or 1.28ms
// - bridge flags bit 6 shows receiver interrupt pending
`timescale 1ns/1ps
`include "bridge_regs_defs.svh"
module bridge_audio_link_status_regs #(
  parameter int STBL_CYC_320US = (`STBL_T2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int STBL_CYC_1280US = (`STBL_T3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic STRAP_PIN_A,
  input wire logic STRAP_PIN_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  output logic [7:0] REG_RDATA,
  input wire logic RX_INT,
  output logic INTERRUPT_OUT_N,
  input wire logic LINK_READY,
  input wire logic TX_ACTIVE,
  input wire logic FAR_LOCKED,
  input wire logic [1:0] TX_PORT_MODE,
  input wire logic TMDS_DECODE_GOOD,
  input wire logic INPUT_PLL_LOCK,
  input wire logic [7:0] TMDS_FREQ_MHZ,
  input wire logic AUDIO_TYPE_CHANGED,
  input wire logic AUDIO_IF_CKSUM_CHANGED,
  input wire logic VIDEO_IF_CKSUM_CHANGED,
  input wire logic CLOCK_REGEN_CHANGED,
  output logic AUDIO_FIFO_FLUSH,
  output logic INT_CTRL_ENABLE,
  output logic RX_AUTO_INIT_EN,
  output logic REMOTE_ID_LOAD_EN,
  output logic TDM_AUDIO_EN,
  output logic AUDIO_SRC_LOCAL,
  output logic AUX_AUDIO_EN,
  output logic TDM_TO_PARALLEL_EN,
  output logic I2S_OUT_EN
);
  localparam int STBL_CYC_40US = (`STBL_T0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int STBL_CYC_80US = (`STBL_T1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  bridge_regs_pkg::cfg_state_t state_reg;
  bridge_regs_pkg::cfg_state_t state_next;
  bridge_regs_pkg::reg_byte_t bridge_reg;
  bridge_regs_pkg::reg_byte_t bridge_next;
  bridge_regs_pkg::reg_byte_t audio_reg;
  bridge_regs_pkg::reg_byte_t audio_next;
  logic [1:0] window_sel_reg;
  logic [1:0] window_sel_next;
  logic [5:0] min_freq_reg;
  logic [5:0] min_freq_next;
  bridge_regs_pkg::reg_byte_t link_status_reg;
  bridge_regs_pkg::reg_byte_t link_status_w;
  bridge_regs_pkg::reg_byte_t flags_w;
  bridge_regs_pkg::reg_byte_t strap_val;
  bridge_regs_pkg::reg_byte_t rdata_next;
  logic [7:0] ctl_next;
  logic [7:0] ctl_reg;
  logic in_strap;
  logic wr_bridge;
  logic wr_audio;
  logic wr_window;
  logic wr_low;
  logic ext_ctrl;
  logic tx_ok_w;
  logic flush_req;
  logic irq_cause;
  logic rem_dis_bit;

  freq_watch_if fw ();

  // ************************************
  // power-up strap capture
  // ************************************
  assign in_strap = state_reg == bridge_regs_pkg::ST_STRAP;

  always_comb begin
    case (state_reg)
      bridge_regs_pkg::ST_STRAP: state_next = bridge_regs_pkg::ST_RUN;
      bridge_regs_pkg::ST_RUN: state_next = bridge_regs_pkg::ST_RUN;
      default: state_next = bridge_regs_pkg::ST_STRAP;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= bridge_regs_pkg::ST_STRAP;
    end else begin
      state_reg <= state_next;
    end
  end

  // strap bits replaced, others keep reset values
  assign strap_val = {STRAP_PIN_B, bridge_reg[6], STRAP_PIN_B,
                      bridge_reg[4:1], STRAP_PIN_A};

  // ************************************
  // register write decode
  // ************************************
  // writes during strap capture are dropped
  assign wr_bridge = REG_WE && !in_strap && (REG_ADDR == `OFS_BRIDGE_CTRL);
  assign wr_audio = REG_WE && !in_strap && (REG_ADDR == `OFS_AUDIO_PATH);
  assign wr_window = REG_WE && !in_strap && (REG_ADDR == `OFS_FREQ_WINDOW);
  assign wr_low = REG_WE && !in_strap && (REG_ADDR == `OFS_FREQ_LOW);

  // reserved bits masked off; status and flags have no write path
  assign bridge_next = in_strap ? strap_val :
                       wr_bridge ? (REG_WDATA & `MASK_BRIDGE_CTRL) :
                       bridge_reg;
  assign audio_next = wr_audio ? (REG_WDATA & `MASK_AUDIO_PATH) : audio_reg;
  assign window_sel_next = wr_window ? REG_WDATA[`FW_SEL_LSB +: 2] : window_sel_reg;
  assign min_freq_next = wr_low ? REG_WDATA[5:0] : min_freq_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bridge_reg <= `RST_BRIDGE_CTRL;
      audio_reg <= `RST_AUDIO_PATH;
      window_sel_reg <= `RST_WINDOW_SEL;
      min_freq_reg <= `RST_MIN_FREQ;
    end else begin
      bridge_reg <= bridge_next;
      audio_reg <= audio_next;
      window_sel_reg <= window_sel_next;
      min_freq_reg <= min_freq_next;
    end
  end

  // ************************************
  // control outputs
  // ************************************
  assign ext_ctrl = bridge_reg[`BC_EXT_CTRL];
  assign rem_dis_bit = bridge_reg[`BC_REM_ID_DIS];

  assign ctl_next[0] = !ext_ctrl;
  assign ctl_next[1] = !ext_ctrl && !bridge_reg[`BC_AUTO_RECEIVER_INIT_DISABLE];
  assign ctl_next[2] = !rem_dis_bit;
  assign ctl_next[3] = bridge_reg[`BC_TDM_AUDIO];
  assign ctl_next[4] = bridge_reg[`BC_AUDIO_LOCAL];
  assign ctl_next[5] = bridge_reg[`BC_AUX_AUDIO];
  assign ctl_next[6] = audio_reg[`AP_TDM_PARALLEL];
  // i2s output only meaningful with extracted audio selected
  assign ctl_next[7] = audio_reg[`AP_I2S_OUT] && !bridge_reg[`BC_AUDIO_LOCAL];

  // internal controller owns the flush; silent under external control
  assign flush_req = !ext_ctrl && (
    (AUDIO_TYPE_CHANGED && audio_reg[`AP_FLUSH_TYPE]) ||
    (AUDIO_IF_CKSUM_CHANGED && audio_reg[`AP_FLUSH_AIF]) ||
    (VIDEO_IF_CKSUM_CHANGED && audio_reg[`AP_FLUSH_AVI]) ||
    (CLOCK_REGEN_CHANGED && audio_reg[`AP_FLUSH_ACR]));

  assign irq_cause = RX_INT && bridge_reg[`BC_RX_INT_EN];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl_reg <= 8'h00;
      AUDIO_FIFO_FLUSH <= 1'b0;
      INTERRUPT_OUT_N <= 1'b1;
    end else begin
      ctl_reg <= ctl_next;
      AUDIO_FIFO_FLUSH <= flush_req;
      INTERRUPT_OUT_N <= !irq_cause;
    end
  end

  assign INT_CTRL_ENABLE = ctl_reg[0];
  assign RX_AUTO_INIT_EN = ctl_reg[1];
  assign REMOTE_ID_LOAD_EN = ctl_reg[2];
  assign TDM_AUDIO_EN = ctl_reg[3];
  assign AUDIO_SRC_LOCAL = ctl_reg[4];
  assign AUX_AUDIO_EN = ctl_reg[5];
  assign TDM_TO_PARALLEL_EN = ctl_reg[6];
  assign I2S_OUT_EN = ctl_reg[7];

  // ************************************
  // frequency watcher
  // ************************************
  assign fw.meas_mhz = TMDS_FREQ_MHZ;
  assign fw.min_mhz = min_freq_reg;
  assign fw.window_sel = window_sel_reg;

  freq_watch #(
    .CYC_W0(STBL_CYC_40US),
    .CYC_W1(STBL_CYC_80US),
    .CYC_W2(STBL_CYC_320US),
    .CYC_W3(STBL_CYC_1280US)
  ) u_freq_watch (
    .clk(CLK),
    .rst(RST),
    .fw(fw.watch)
  );

  // ************************************
  // link status
  // ************************************
  // valid input: good decode on a settled clock
  assign tx_ok_w = TX_ACTIVE && FAR_LOCKED && TMDS_DECODE_GOOD && fw.settled &&
                   (TX_PORT_MODE == `PORT_MODE_SINGLE0);
  assign link_status_w = {LINK_READY,
                          tx_ok_w,
                          tx_ok_w ? TX_PORT_MODE : 2'h0,
                          TMDS_DECODE_GOOD, INPUT_PLL_LOCK,
                          fw.no_clock,
                          fw.settled};
  assign flags_w = {1'b0, RX_INT, 6'h00};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      link_status_reg <= 8'h00;
    end else begin
      link_status_reg <= link_status_w;
    end
  end

  // ************************************
  // register read
  // ************************************
  assign rdata_next =
    (REG_ADDR == `OFS_BRIDGE_FLAGS) ? flags_w :
    (REG_ADDR == `OFS_BRIDGE_CTRL) ? bridge_reg :
    (REG_ADDR == `OFS_AUDIO_PATH) ? audio_reg :
    (REG_ADDR == `OFS_LINK_STATUS) ? link_status_reg :
    (REG_ADDR == `OFS_FREQ_WINDOW) ? {3'h0, window_sel_reg, 3'h0} :
    (REG_ADDR == `OFS_FREQ_LOW) ? {2'h0, min_freq_reg} : 8'h00;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RE) begin
      REG_RDATA <= rdata_next;
    end
  end

  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_ext_ctrl;
    ext_ctrl |=> !INT_CTRL_ENABLE && !RX_AUTO_INIT_EN;
  endproperty
  a_ext_ctrl: assert property (p_ext_ctrl) else $error("ext control left init on");

  property p_strap;
    in_strap |=> bridge_reg[7] == $past(STRAP_PIN_B) && bridge_reg[5] == $past(STRAP_PIN_B)
      && bridge_reg[0] == $past(STRAP_PIN_A);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");

  property p_irq;
    1'b1 |=> INTERRUPT_OUT_N == !$past(irq_cause);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pin wrong");

  property p_remote_load;
    1'b1 |=> REMOTE_ID_LOAD_EN != $past(rem_dis_bit);
  endproperty
  a_remote_load: assert property (p_remote_load) else $error("remote load wrong");

  property p_i2s_out;
    bridge_reg[`BC_AUDIO_LOCAL] |=> !I2S_OUT_EN;
  endproperty
  a_i2s_out: assert property (p_i2s_out) else $error("i2s out with local audio");

  property p_flush_type;
    AUDIO_TYPE_CHANGED && audio_reg[`AP_FLUSH_TYPE] && !ext_ctrl |=> AUDIO_FIFO_FLUSH;
  endproperty
  a_flush_type: assert property (p_flush_type) else $error("type flush missed");

  property p_no_flush;
    !AUDIO_TYPE_CHANGED && !AUDIO_IF_CKSUM_CHANGED && !VIDEO_IF_CKSUM_CHANGED
      && !CLOCK_REGEN_CHANGED |=> !AUDIO_FIFO_FLUSH;
  endproperty
  a_no_flush: assert property (p_no_flush) else $error("spurious flush");

  property p_tx_ok;
    link_status_reg[6] |-> $past(TX_ACTIVE) && $past(FAR_LOCKED) && $past(fw.settled);
  endproperty
  a_tx_ok: assert property (p_tx_ok) else $error("tx status without cause");

  property p_port;
    !link_status_reg[6] |-> link_status_reg[5:4] == 2'h0;
  endproperty
  a_port: assert property (p_port) else $error("port mode shown while idle");

  property p_no_clock;
    TMDS_FREQ_MHZ <= {2'h0, min_freq_reg} ##1 $stable(min_freq_reg) |-> fw.no_clock;
  endproperty
  a_no_clock: assert property (p_no_clock) else $error("no-clock flag missed");

  property p_reserved;
    !bridge_reg[3] && audio_reg[5:4] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_link_read;
    REG_RE && REG_ADDR == `OFS_LINK_STATUS |=> REG_RDATA[7] == $past(LINK_READY, 2);
  endproperty
  a_link_read: assert property (p_link_read) else $error("link ready read wrong");

  property p_ext_no_flush;
    ext_ctrl |=> !AUDIO_FIFO_FLUSH;
  endproperty
  a_ext_no_flush: assert property (p_ext_no_flush) else $error("flush under ext control");

  property p_auto_init;
    !ext_ctrl && !bridge_reg[`BC_AUTO_RECEIVER_INIT_DISABLE] |=> RX_AUTO_INIT_EN;
  endproperty
  a_auto_init: assert property (p_auto_init) else $error("auto init not enabled");

  property p_port_single;
    link_status_reg[6] |-> link_status_reg[5:4] == `PORT_MODE_SINGLE0;
  endproperty
  a_port_single: assert property (p_port_single) else $error("port mode not shown");

  c_flush: cover property (flush_req ##1 AUDIO_FIFO_FLUSH);
  c_irq: cover property (irq_cause ##1 !INTERRUPT_OUT_N);
  c_settled: cover property (!fw.settled ##1 fw.settled);
  c_tx_ok: cover property (link_status_reg[6]);
endmodule // bridge_audio_link_status_regs

// ### bench/host_port_model.sv
// bus master model of the register port, standing in for the control bus host
`timescale 1ns/1ps
module host_port_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic we,
  output logic re
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    we = 1'b0;
    re = 1'b0;
  end

  // one byte per call; the host does all sequencing under external control
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    wdata <= ~d;
  endtask

  // data is taken just after the edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // host_port_model

// ### bench/bridge_audio_link_status_regs_tb.sv
// self-checking testbench of the bridge register bank
`timescale 1ns/1ps
module bridge_audio_link_status_regs_tb;
  localparam int LIM1 = 80000 / 25;
  localparam int LIM2 = 40;
  localparam int LIM3 = 60;
  logic clk, rst, strap_a, strap_b, we, re, rx_int, int_n, flush;
  logic link_rdy, tx_act, far_lock, dec_good, pll_lock;
  logic [1:0] port_mode;
  logic [7:0] addr, wdata, rdata, freq, ctl, v, b, a;
  logic [3:0] chg;
  logic [7:0] ra [5] = '{8'h54, 8'h55, 8'h5c, 8'h5d, 8'h77};
  logic [7:0] rv [5] = '{8'h01, 8'h0c, 8'h00, 8'h06, 8'h00};
  int err_total;
  int checks_done;
  int lim;

  bridge_audio_link_status_regs #(.STBL_CYC_320US(LIM2), .STBL_CYC_1280US(LIM3)) i_dut (
    .CLK(clk), .RST(rst), .STRAP_PIN_A(strap_a), .STRAP_PIN_B(strap_b),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata),
    .RX_INT(rx_int), .INTERRUPT_OUT_N(int_n), .LINK_READY(link_rdy), .TX_ACTIVE(tx_act),
    .FAR_LOCKED(far_lock), .TX_PORT_MODE(port_mode), .TMDS_DECODE_GOOD(dec_good),
    .INPUT_PLL_LOCK(pll_lock), .TMDS_FREQ_MHZ(freq), .AUDIO_TYPE_CHANGED(chg[3]),
    .AUDIO_IF_CKSUM_CHANGED(chg[2]), .VIDEO_IF_CKSUM_CHANGED(chg[1]),
    .CLOCK_REGEN_CHANGED(chg[0]), .AUDIO_FIFO_FLUSH(flush), .INT_CTRL_ENABLE(ctl[7]),
    .RX_AUTO_INIT_EN(ctl[6]), .REMOTE_ID_LOAD_EN(ctl[5]), .TDM_AUDIO_EN(ctl[4]),
    .AUDIO_SRC_LOCAL(ctl[3]), .AUX_AUDIO_EN(ctl[2]), .TDM_TO_PARALLEL_EN(ctl[1]),
    .I2S_OUT_EN(ctl[0])
  );

  host_port_model i_host (
    .clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .we(we), .re(re)
  );

  // ************************************************************
  // expectations and helpers
  // ************************************************************
  function automatic logic [7:0] exp_ctl(input logic [7:0] bc, input logic [7:0] ap);
    return {~bc[7], ~bc[7] & ~bc[4], ~bc[5], bc[2], bc[1], bc[0], ap[7], ap[6] & ~bc[1]};
  endfunction

  function automatic logic [7:0] exp_sts(input logic nc, input logic st);
    logic ok;
    ok = tx_act & far_lock & dec_good & st & (port_mode == 2'h1);
    return {link_rdy, ok, ok ? port_mode : 2'h0, dec_good, pll_lock, nc, st};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic pa, input logic pb);
    strap_a <= pa;
    strap_b <= pb;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // change pulse, then flush expected one cycle later for one cycle only
  task automatic pulse(input logic [3:0] p, input logic exp);
    @(posedge clk);
    chg <= p;
    @(posedge clk);
    chg <= 4'h0;
    #1 chk({7'h0, flush}, {7'h0, exp});
    @(posedge clk);
    #1 chk({7'h0, flush}, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("watchdog expired");
    end_of_test();
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    err_total = 0;
    checks_done = 0;
    rst = 1'b1;
    strap_a = 1'b1;
    strap_b = 1'b0;
    rx_int = 1'b0;
    {link_rdy, tx_act, far_lock, dec_good, pll_lock, port_mode} = 7'h00;
    freq = 8'd74;
    chg = 4'h0;
    v = 8'($urandom(54643));
    do_reset(1'b1, 1'b0);
    repeat (1500) @(posedge clk);
    i_host.rd(8'h5a, v);
    chk(v & 8'h01, 8'h00);
    repeat (200) @(posedge clk);
    i_host.rd(8'h5a, v);
    chk(v & 8'h01, 8'h01);
    $display("test settle_default done");
    for (int i = 0; i < 5; i++) begin
      i_host.rd(ra[i], v);
      chk(v, rv[i]);
    end
    chk(ctl, exp_ctl(8'h01, 8'h0c));
    $display("test reset_values done");
    for (int i = 0; i < 12; i++) begin
      b = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      a = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      i_host.wr(8'h54, b);
      i_host.wr(8'h55, a);
      i_host.wr(8'h77, 8'($urandom));
      i_host.rd(8'h54, v);
      chk(v, b & 8'hf7);
      i_host.rd(8'h55, v);
      chk(v, a & 8'hcf);
      chk(ctl, exp_ctl(b & 8'hf7, a & 8'hcf));
    end
    $display("test config_random done");
    for (int en = 0; en < 2; en++) begin
      i_host.wr(8'h54, 8'(en << 6));
      for (int x = 0; x < 2; x++) begin
        @(posedge clk);
        rx_int <= 1'(x);
        @(posedge clk);
        #1 chk({7'h0, int_n}, {7'h0, ~(1'(x) & 1'(en))});
        i_host.rd(8'h50, v);
        chk(v, {1'b0, 1'(x), 6'h00});
      end
    end
    $display("test interrupt done");
    i_host.wr(8'h54, 8'h00);
    for (int i = 0; i < 4; i++) begin
      i_host.wr(8'h55, 8'(1 << i));
      pulse(4'(1 << i), 1'b1);
      pulse(~4'(1 << i), 1'b0);
    end
    i_host.wr(8'h55, 8'h0f);
    pulse(4'hf, 1'b1);
    i_host.wr(8'h54, 8'h80);
    pulse(4'hf, 1'b0);
    i_host.wr(8'h54, 8'h00);
    $display("test flush done");
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      {link_rdy, tx_act, far_lock, dec_good, pll_lock, port_mode} <= (i == 0) ? 7'h7d
        : 7'($urandom);
      i_host.wr(8'h5a, 8'($urandom));
      i_host.rd(8'h5a, v);
      chk(v, exp_sts(1'b0, 1'b1));
    end
    $display("test link_status done");
    i_host.wr(8'h5d, 8'hd4);
    i_host.rd(8'h5d, v);
    chk(v, 8'h14);
    for (int f = 19; f < 22; f++) begin
      @(posedge clk);
      freq <= 8'(f);
      repeat (3) @(posedge clk);
      i_host.rd(8'h5a, v);
      chk(v & 8'h02, (f <= 20) ? 8'h02 : 8'h00);
    end
    $display("test low_threshold done");
    for (int s = 1; s < 4; s++) begin
      lim = (s == 1) ? LIM1 : (s == 2) ? LIM2 : LIM3;
      i_host.wr(8'h5c, 8'(s << 3));
      i_host.rd(8'h5c, v);
      chk(v, 8'(s << 3));
      @(posedge clk);
      freq <= 8'(100 + s * 10);
      repeat (lim - 10) @(posedge clk);
      i_host.rd(8'h5a, v);
      chk(v & 8'h01, 8'h00);
      repeat (20) @(posedge clk);
      i_host.rd(8'h5a, v);
      chk(v & 8'h01, 8'h01);
      @(posedge clk);
      freq <= freq + 8'd2;
      repeat (5) @(posedge clk);
      i_host.rd(8'h5a, v);
      chk(v & 8'h01, 8'h01);
    end
    $display("test stability_window done");
    do_reset(1'b0, 1'b1);
    i_host.rd(8'h54, v);
    chk(v, 8'ha0);
    chk(ctl, exp_ctl(8'ha0, 8'h0c));
    $display("test strap_reload done");
    end_of_test();
  end
endmodule // bridge_audio_link_status_regs_tb
